// File: include/fprc_params.svh
// Purpose: Constants for the flash power and reset protection controller.
// Assumes: A 10 MHz system clock.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
`ifndef FPRC_PARAMS_SVH
`define FPRC_PARAMS_SVH
`define FPRC_CLK_MHZ 10
`define FPRC_WAKE_READ_NS 600
`define FPRC_WAKE_WRITE_NS 1000
`define FPRC_RESET_LOW_NS 100
`define FPRC_STROBE_NS 100
`define FPRC_CYC(ns) (((ns) * `FPRC_CLK_MHZ + 999) / 1000)
`define FPRC_OFF_CTRL 8'h00
`define FPRC_OFF_CMD 8'h04
`define FPRC_OFF_STATUS 8'h08
`define FPRC_OFF_RDATA 8'h0C
`define FPRC_CMD_READ_ARRAY 8'hFF
`define FPRC_CMD_READ_STATUS 8'h70
`define FPRC_CMD_CLEAR_STATUS 8'h50
`define FPRC_SR_SUPPLY_LOW 3
`define FPRC_SR_WRITE_ERR 4
`define FPRC_SR_ERASE_ERR 5
`define FPRC_SR_READY 7
`define FPRC_RESP_OKAY 2'b00
`define FPRC_RESP_DECERR 2'b11
`define FPRC_RESP_SLVERR 2'b10
`define FPRC_CTRL_PD_BIT 0
`define FPRC_CTRL_RA_BIT 1
`define FPRC_CMD_RD_BIT 31
`define FPRC_CMD_ADDR_LSB 8
`endif

// File: include/fprc_pkg.sv
// Purpose: Types for the flash power and reset protection controller.
// Assumes: Nothing beyond the parameter header.
// Notes: The sequencer walks one bus cycle on the flash pins at a time.
package fprc_pkg;
    typedef enum logic [2:0] {
        FprcIdle,
        FprcSetup,
        FprcStrobe,
        FprcHold,
        FprcPowerDown,
        FprcWake
    } fprc_state_t;
endpackage

// File: logic/fprc_host.sv
// Purpose: Host controller that drives the flash reset, strobes and data pins.
// Assumes: Software orders writes, reads and power-down over AXI4-Lite.
// Notes on behaviour
// R1: Device sets supply-low with write or erase error on supply failure.
// R2: Reset low during an operation aborts it and enters deep power-down.
// R3: Host reissues the whole command sequence after an aborted operation; the code clears busy and sets the aborted status bit instead of reissuing.
// R4: Device clears status on power-off and whenever reset goes low.
// R5: Device keeps its last command regardless of supply or select changes.
// R6: Device returns to read-array at power-up, wake and core lockout.
// R7: Host writes read-array before reading the array after any operation.
// R8: Device works whichever supply rises first.
// R9: Writes happen only with write strobe and chip select both low.
// R10: Device ignores all control inputs while reset is low.
// R11: Data-altering operations need a setup write then a confirm write.
// R12: Host keeps supplies valid and reset high during operations.
// R13: Host waits wake delays before reading or writing after reset rises.
// R14: Reset is driven from the supply-valid signal and system reset.
// R15: Chip select is decoded per device; output strobe is shared.
// R16: Device floats data and latches nothing in deep power-down.
// R17: Supply-low bit is one after a supply abort, else zero.
// R18: Write error bit is one after a failed write, else zero.
// R19: Host returns the device to read-array by writing its command code.
// Notes: CTRL bit0 requests power-down, bit1 sets read-array after each write command other than read-array itself.
`timescale 1ns/1ps
`include "fprc_params.svh"
module fprc_host #(
    parameter int ADDR_W = 20
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic supplyValid,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [7:0] flashDataOut,
    output logic flashDataOe,
    input wire logic [7:0] flashDataIn,
    output logic chipSelectN,
    output logic writeStrobeN,
    output logic outputStrobeN,
    output logic resetPowerdownN
);
    import fprc_pkg::*;
    localparam int WakeReadCyc = `FPRC_CYC(`FPRC_WAKE_READ_NS);
    localparam int WakeWriteCyc = `FPRC_CYC(`FPRC_WAKE_WRITE_NS);
    localparam int LowCyc = `FPRC_CYC(`FPRC_RESET_LOW_NS);
    localparam int StrobeCyc = `FPRC_CYC(`FPRC_STROBE_NS);
    localparam int CntW = 8;

    typedef struct packed {
        fprc_state_t state;
        logic [CntW-1:0] cnt;
        logic [CntW-1:0] wakeCnt;
        logic sv1;
        logic sv2;
        logic pdReq;
        logic autoRa;
        logic raPending;
        logic isRead;
        logic [ADDR_W-1:0] addr;
        logic [7:0] dout;
        logic [7:0] rdByte;
        logic [7:0] din1;
        logic [7:0] din2;
        logic rdCap;
        logic busy;
        logic aborted;
        logic awHeld;
        logic wHeld;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic dataOe;
        logic csN;
        logic weN;
        logic oeN;
        logic rpN;
    } fprc_regs_t;

    fprc_regs_t q_r;
    fprc_regs_t q_nxt;

    function automatic logic [CntW-1:0] cycles(input int n);
        cycles = CntW'(n < 1 ? 1 : n);
    endfunction

    always_comb begin
        q_nxt = q_r;
        q_nxt.sv1 = supplyValid;
        q_nxt.sv2 = q_r.sv1;
        q_nxt.din1 = flashDataIn;
        q_nxt.din2 = q_r.din1;
        q_nxt.rdCap = 1'b0;
        if (q_r.rdCap) begin
            q_nxt.rdByte = q_r.din2;
        end
        q_nxt.awready = 1'b0;
        q_nxt.wready = 1'b0;
        q_nxt.arready = 1'b0;
        if (q_r.wakeCnt != '0) begin
            q_nxt.wakeCnt = q_r.wakeCnt - 1'b1;
        end
        if (awvalid && !q_r.awHeld && !q_r.awready) begin
            q_nxt.awready = 1'b1;
            q_nxt.awHeld = 1'b1;
            q_nxt.awAddr = awaddr;
        end
        if (wvalid && !q_r.wHeld && !q_r.wready) begin
            q_nxt.wready = 1'b1;
            q_nxt.wHeld = 1'b1;
            q_nxt.wData = wdata;
            q_nxt.wStrb = wstrb;
        end
        if (q_r.bvalid && bready) begin
            q_nxt.bvalid = 1'b0;
        end
        if (q_r.awHeld && q_r.wHeld && !q_r.bvalid) begin
            q_nxt.awHeld = 1'b0;
            q_nxt.wHeld = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = `FPRC_RESP_OKAY;
            if (q_r.awAddr == `FPRC_OFF_CTRL) begin
                if (q_r.wStrb[0]) begin
                    q_nxt.pdReq = q_r.wData[`FPRC_CTRL_PD_BIT];
                    q_nxt.autoRa = q_r.wData[`FPRC_CTRL_RA_BIT];
                end
            end else if (q_r.awAddr == `FPRC_OFF_CMD) begin
                if (!q_r.busy && !q_r.raPending && q_r.state == FprcIdle) begin
                    q_nxt.busy = 1'b1;
                    q_nxt.aborted = 1'b0;
                    q_nxt.isRead = q_r.wData[`FPRC_CMD_RD_BIT];
                    q_nxt.dout = q_r.wData[7:0];
                    q_nxt.addr = q_r.wData[`FPRC_CMD_ADDR_LSB +: ADDR_W];
                end else begin
                    q_nxt.bresp = `FPRC_RESP_SLVERR;
                end
            end else if (q_r.awAddr != `FPRC_OFF_STATUS && q_r.awAddr != `FPRC_OFF_RDATA) begin
                q_nxt.bresp = `FPRC_RESP_DECERR;
            end
        end
        if (q_r.rvalid && rready) begin
            q_nxt.rvalid = 1'b0;
        end
        if (arvalid && !q_r.rvalid && !q_r.arready) begin
            q_nxt.arready = 1'b1;
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp = `FPRC_RESP_OKAY;
            case (araddr)
                `FPRC_OFF_CTRL: q_nxt.rdata = {30'h0000_0000, q_r.autoRa, q_r.pdReq};
                `FPRC_OFF_CMD: q_nxt.rdata = {q_r.isRead, 3'h0, 20'(q_r.addr), q_r.dout};
                `FPRC_OFF_STATUS: q_nxt.rdata = {26'h000_0000, q_r.wakeCnt != '0, q_r.aborted,
                    q_r.state == FprcPowerDown, !q_r.rpN, q_r.raPending, q_r.busy};
                `FPRC_OFF_RDATA: q_nxt.rdata = {24'h00_0000, q_r.rdByte};
                default: begin
                    q_nxt.rdata = 32'h0000_0000;
                    q_nxt.rresp = `FPRC_RESP_DECERR;
                end
            endcase
        end
        case (q_r.state)
            FprcIdle: begin
                q_nxt.csN = 1'b1;
                q_nxt.weN = 1'b1;
                q_nxt.oeN = 1'b1;
                q_nxt.dataOe = 1'b0;
                // R12: reset between cycles
                // R14: supply reset
                if (!q_r.sv2 || q_r.pdReq) begin
                    q_nxt.rpN = 1'b0;
                    q_nxt.cnt = cycles(LowCyc);
                    q_nxt.state = FprcPowerDown;
                // R7: read-array first
                end else if (q_r.raPending) begin
                    q_nxt.dout = `FPRC_CMD_READ_ARRAY;
                    q_nxt.isRead = 1'b0;
                    q_nxt.state = FprcSetup;
                end else if (q_r.busy) begin
                    // R13: wake delays
                    if (q_r.wakeCnt == '0 || (q_r.isRead &&
                        q_r.wakeCnt <= cycles(WakeWriteCyc - WakeReadCyc))) begin
                        q_nxt.state = FprcSetup;
                    end
                end
            end
            FprcSetup: begin
                q_nxt.csN = 1'b0;
                // R15: select gates strobe
                q_nxt.oeN = !q_r.isRead;
                q_nxt.dataOe = !q_r.isRead;
                q_nxt.cnt = cycles(StrobeCyc);
                q_nxt.state = FprcStrobe;
            end
            FprcStrobe: begin
                // R9: write strobe low with select, output strobe high
                q_nxt.weN = q_r.isRead;
                q_nxt.cnt = q_r.cnt - 1'b1;
                if (q_r.cnt == CntW'(1)) begin
                    q_nxt.state = FprcHold;
                end
            end
            FprcHold: begin
                q_nxt.weN = 1'b1;
                q_nxt.oeN = 1'b1;
                q_nxt.state = FprcIdle;
                q_nxt.rdCap = q_r.isRead;
                q_nxt.busy = 1'b0;
                // R19: read-array code
                q_nxt.raPending = q_r.autoRa && !q_r.isRead && q_r.dout != `FPRC_CMD_READ_ARRAY;
            end
            FprcPowerDown: begin
                q_nxt.csN = 1'b1;
                q_nxt.weN = 1'b1;
                q_nxt.oeN = 1'b1;
                q_nxt.dataOe = 1'b0;
                // R3: abort is reported
                if (q_r.busy) begin
                    q_nxt.aborted = 1'b1;
                    q_nxt.busy = 1'b0;
                end
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - 1'b1;
                end else if (q_r.sv2 && !q_r.pdReq) begin
                    q_nxt.rpN = 1'b1;
                    q_nxt.state = FprcWake;
                end
            end
            FprcWake: begin
                q_nxt.wakeCnt = cycles(WakeWriteCyc);
                q_nxt.raPending = 1'b0;
                q_nxt.state = FprcIdle;
            end
            default: q_nxt.state = FprcIdle;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '0;
            q_r.state <= FprcIdle;
            q_r.csN <= 1'b1;
            q_r.weN <= 1'b1;
            q_r.oeN <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign awready = q_r.awready;
    assign wready = q_r.wready;
    assign bvalid = q_r.bvalid;
    assign bresp = q_r.bresp;
    assign arready = q_r.arready;
    assign rvalid = q_r.rvalid;
    assign rdata = q_r.rdata;
    assign rresp = q_r.rresp;
    assign flashAddr = q_r.addr;
    assign flashDataOut = q_r.dout;
    assign flashDataOe = q_r.dataOe;
    assign chipSelectN = q_r.csN;
    assign writeStrobeN = q_r.weN;
    assign outputStrobeN = q_r.oeN;
    assign resetPowerdownN = q_r.rpN;
endmodule

// File: testbench/fprc_host_properties.sv
// Purpose: Pin timing checks for the flash host.
// Assumes: Wake delays come from the shared constants.
// Notes: Bound to every host instance.
`timescale 1ns/1ps
`include "fprc_params.svh"
module fprc_host_properties (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic supplyValid,
    input wire logic flashDataOe,
    input wire logic chipSelectN,
    input wire logic writeStrobeN,
    input wire logic outputStrobeN,
    input wire logic resetPowerdownN
);
    localparam int WakeWr = `FPRC_CYC(`FPRC_WAKE_WRITE_NS) - 1;
    localparam int WakeRd = `FPRC_CYC(`FPRC_WAKE_READ_NS) - 1;
    logic [7:0] wake_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_r <= 8'h00;
        end else if (!resetPowerdownN) begin
            wake_r <= 8'h00;
        end else if (wake_r != 8'hFF) begin
            wake_r <= wake_r + 8'h01;
        end
    end
    a_write_wake: assert property (!writeStrobeN |-> wake_r >= WakeWr)
        else $error("write strobe too soon after wake");
    a_read_wake: assert property (!outputStrobeN |-> wake_r >= WakeRd)
        else $error("read strobe too soon after wake");
    a_write_select: assert property (!writeStrobeN |-> !chipSelectN && flashDataOe && outputStrobeN)
        else $error("write strobe without select or data");
    a_read_float: assert property (!outputStrobeN |-> !chipSelectN && !flashDataOe)
        else $error("read strobe while driving data");
    a_write_pulse: assert property ($fell(writeStrobeN) |=> writeStrobeN && !chipSelectN)
        else $error("write strobe width or select hold wrong");
    a_reset_quiet: assert property (!resetPowerdownN |-> writeStrobeN && outputStrobeN)
        else $error("strobe active while reset low");
    a_supply_drop: assert property ($fell(supplyValid) |-> ##[1:4] !resetPowerdownN)
        else $error("reset not lowered on supply drop");
    a_supply_hold: assert property (!supplyValid [*4] |-> !resetPowerdownN)
        else $error("reset high while supply low");
endmodule
bind fprc_host fprc_host_properties u_props (.*);

// File: testbench/fprc_flash_model.sv
// Purpose: Behavioural flash device facing the host.
// Assumes: Operations finish at once; the array starts erased.
// Notes: Only 256 bytes are modelled.
`timescale 1ns/1ps
module fprc_flash_model (
    input wire logic [19:0] flashAddr,
    input wire logic [7:0] flashDataOut,
    input wire logic chipSelectN,
    input wire logic writeStrobeN,
    input wire logic outputStrobeN,
    input wire logic resetPowerdownN,
    input wire logic supplyOk,
    output logic [7:0] flashDataIn
);
    logic [7:0] mem [256];
    logic [7:0] sr = 8'h00;
    logic [7:0] setup = 8'h00;
    logic [7:0] last = 8'h00;
    logic stMode = 1'h0;
    wire [7:0] rd = stMode ? (sr | 8'h80) : mem[flashAddr[7:0]];
    // power-up state does not depend on supply order.
    initial foreach (mem[k]) mem[k] = 8'hFF;
    // reset low aborts, clears status, selects read array.
    always @(negedge resetPowerdownN) begin
        sr = 8'h00;
        setup = 8'h00;
        stMode = 1'h0;
    end
    // commands latch as the write strobe rises.
    always @(posedge writeStrobeN) begin
        if (!chipSelectN && resetPowerdownN) begin
            if (setup == 8'h40) begin
                if (supplyOk) mem[flashAddr[7:0]] &= flashDataOut;
                else sr = sr | 8'h18;
                setup = 8'h00;
            end else begin
                setup = flashDataOut;
                stMode = flashDataOut != 8'hFF;
                if (flashDataOut == 8'h50) sr = 8'h00;
            end
        end
    end
    // undriven data shows the inverse of the last byte.
    always @(posedge outputStrobeN) last = rd;
    assign flashDataIn = (resetPowerdownN && !chipSelectN && !outputStrobeN) ? rd : ~last;
endmodule

// File: testbench/tb_fprc_host.sv
// Purpose: Self-checking bench for the flash host.
// Assumes: The flash model answers at once.
// Notes: Random bytes come from a fixed seed.
`timescale 1ns/1ps
`include "fprc_params.svh"
module tb_fprc_host;
    logic sys_clk, arst_n, supplyValid, supplyOk, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, flashDataOe, chipSelectN, writeStrobeN, outputStrobeN;
    logic resetPowerdownN;
    logic [1:0] bresp, rresp, rs;
    logic [3:0] wstrb;
    logic [7:0] awaddr, araddr, flashDataOut, flashDataIn, a, d;
    logic [7:0] expMem [256];
    logic [19:0] flashAddr;
    logic [31:0] wdata, rdata, rv;
    int error_cnt = 0;
    int checked = 0;
    int i;
    fprc_host dut (.*);
    fprc_flash_model flash (.*);
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] stat(input logic fail);
        return fail ? 32'h0000_0098 : 32'h0000_0080;
    endfunction
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang;
        error_cnt++;
        print_verdict;
    endtask
    task automatic axiWr(input logic [7:0] ad, input logic [31:0] dd);
        int n;
        awaddr <= ad;
        wdata <= dd;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 40 && !bvalid; n++) begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        rs = bresp;
        bready <= 1'h0;
        if (n == 40) hang;
        @(posedge sys_clk);
    endtask
    task automatic axiRd(input logic [7:0] ad);
        int n;
        araddr <= ad;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 40 && !rvalid; n++) begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'h0;
        end
        rv = rdata;
        rs = rresp;
        rready <= 1'h0;
        if (n == 40) hang;
        @(posedge sys_clk);
    endtask
    task automatic waitSt(input logic [31:0] m, input logic [31:0] v);
        int n;
        for (n = 0; n < 200; n++) begin
            axiRd(`FPRC_OFF_STATUS);
            if ((rv & m) === v) break;
        end
        if (n == 200) hang;
    endtask
    task automatic cmd(input logic [7:0] fa, input logic [7:0] fd, input logic r);
        axiWr(`FPRC_OFF_CMD, {r, 15'h0, fa, fd});
        chk(rs, `FPRC_RESP_OKAY);
        waitSt(32'h0000_002B, 32'h0);
    endtask
    task automatic rdb(input logic [7:0] fa);
        cmd(fa, 8'h00, 1'h1);
        axiRd(`FPRC_OFF_RDATA);
    endtask
    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {supplyValid, supplyOk, wstrb} = 6'h3F;
        void'($urandom(32'h6801));
        foreach (expMem[k]) expMem[k] = 8'hFF;
        repeat (16) @(posedge sys_clk);
        chk({chipSelectN, writeStrobeN, outputStrobeN, resetPowerdownN}, 32'h0000_000E);
        arst_n <= 1'h1;
        waitSt(32'h0000_0029, 32'h0);
        $display("Reset test done");
        for (i = 0; i < 6; i++) begin
            a = (i == 1) ? 8'hFF : 8'($urandom);
            d = (i == 0) ? 8'h00 : 8'($urandom);
            cmd(a, 8'h40, 1'h0);
            cmd(a, d, 1'h0);
            expMem[a] = expMem[a] & d;
            rdb(a);
            chk(rv, stat(1'h0));
            cmd(a, `FPRC_CMD_READ_ARRAY, 1'h0);
            rdb(a);
            chk(rv, 32'(expMem[a]));
        end
        $display("Program test done");
        supplyOk <= 1'h0;
        cmd(a, 8'h40, 1'h0);
        cmd(a, 8'h00, 1'h0);
        rdb(a);
        chk(rv, stat(1'h1));
        axiWr(`FPRC_OFF_CTRL, 32'h0000_0001);
        waitSt(32'h0000_0008, 32'h0000_0008);
        supplyOk <= 1'h1;
        axiWr(`FPRC_OFF_CTRL, 32'h0);
        axiWr(`FPRC_OFF_CMD, {16'h0000, a, `FPRC_CMD_READ_STATUS});
        chk(rs, `FPRC_RESP_OKAY);
        axiWr(`FPRC_OFF_CTRL, 32'h0000_0001);
        waitSt(32'h0000_0018, 32'h0000_0018);
        chk(rv & 32'h0000_0011, 32'h0000_0010);
        axiWr(`FPRC_OFF_CTRL, 32'h0);
        waitSt(32'h0000_0029, 32'h0);
        rdb(a);
        chk(rv, 32'(expMem[a]));
        cmd(a, `FPRC_CMD_READ_STATUS, 1'h0);
        rdb(a);
        chk(rv, stat(1'h0));
        supplyValid <= 1'h0;
        waitSt(32'h0000_0004, 32'h0000_0004);
        supplyValid <= 1'h1;
        waitSt(32'h0000_0029, 32'h0);
        $display("Power test done");
        axiWr(`FPRC_OFF_CTRL, 32'h0000_0002);
        cmd(a, `FPRC_CMD_READ_STATUS, 1'h0);
        rdb(a);
        chk(rv, 32'(expMem[a]));
        axiWr(8'h10, 32'h0);
        chk(rs, `FPRC_RESP_DECERR);
        axiRd(8'h14);
        chk(rs, `FPRC_RESP_DECERR);
        $display("Control test done");
        print_verdict;
    end
endmodule
